//--- rtl/bia_top.v
// bia_top.v: interrupt handler, slot-1 chain driver and local interrupter
// assumes: one core_clk; bus pins come in asynchronous and are synchronised
// here; the on-board requester/arbiter handles bus ownership.
//
// Functional notes
// - with all seven lines watched, line 7 wins and line 1 is lowest.
// - a subset handler prioritises highest-numbered line; arbitration orders handlers.
// - a low monitored request line raises the bus request to the requester.
// - no status/id read begins before the bus grant arrives.
// - after grant, drive the 3-bit code on a03..a01, iack low, as low.
// - slot-1 driver makes a falling chain-out edge when its iack input falls.
// - interrupter compares address code with its driven line on chain-in fall.
// - on match, wait for strobes low, then drive status/id and dtack low.
// - on dtack low handler captures status/id and fires the service pulse.
// - a non-matching interrupter passes the chain edge on and stays silent.
`timescale 1ns/1ps
`default_nettype none
`include "bia_defines.vh"

module bia_top #(
    parameter ID_W = `BIA_ID_W
) (
    input  wire            core_clk,      // 20 MHz clock
    input  wire            resetn,        // sync reset, active low
    input  wire [7:1]      line_enable,   // lines this handler monitors
    input  wire            slot1,         // board sits in slot 1
    // request lines, active low, from pins
    input  wire [7:1]      irq_n,         // request lines
    // requester handshake
    output reg             bus_req,       // need data transfer bus
    input  wire            bus_grant,     // bus granted (same clock)
    output wire            bus_done,      // release bus, held high until dtack lifts
    // acknowledge cycle pins
    output reg  [2:0]      addr_out,      // a03..a01 acknowledge code
    output reg             addr_oe_n,     // address drive enable, low drives
    output reg             iack_n,        // iack line
    output reg             as_n,          // address strobe
    output reg             ds_n,          // data strobe
    input  wire            dtack_in_n,    // dtack from bus
    input  wire [ID_W-1:0] data_in,       // data bus in
    // chain pins
    input  wire            iackin_n,      // chain input
    output wire            iackout_n,     // chain output
    // local interrupter
    input  wire [2:0]      local_line,    // line local interrupter drives, 0 none
    input  wire [ID_W-1:0] local_id,      // its status/id
    output wire            local_dtack_n, // its dtack
    output wire            local_data_oe_n, // its data drive enable
    output wire [ID_W-1:0] local_data,    // its status/id out
    // service side
    output reg  [ID_W-1:0] vector,        // captured status/id
    output reg  [2:0]      vector_line,   // line that was served
    output reg             service        // one-cycle service trigger
);
    reg [7:1]     irq_s1, irq_s2;
    reg           dtk_s1, dtk_s2, ack_s1, ack_s2;
    reg [2:0]     st;
    reg [7:1]     en_s1, en_s2;
    reg           slot_s1, slot_s2;
    reg           drv_ack_n;
    wire          chain_mid_n;
    wire [7:1]    pend;
    wire [2:0]    top_line;

    // handler states, binary coded
    localparam [2:0] ST_IDLE = `BIA_ST_IDLE;
    localparam [2:0] ST_REQ  = `BIA_ST_REQ;
    localparam [2:0] ST_ACK  = `BIA_ST_ACK;
    localparam [2:0] ST_STRB = `BIA_ST_STRB;
    localparam [2:0] ST_DONE = `BIA_ST_DONE;

    // true when a code names a real line
    function bia_live;
        input [2:0] code;
        begin
            bia_live = (code != `BIA_CODE_NONE);
        end
    endfunction

    // highest pending line number, 0 if none
    function [2:0] bia_pick;
        input [7:1] p;
        integer i;
        begin
            bia_pick = `BIA_CODE_NONE;
            for (i = 1; i <= `BIA_NUM_LINES; i = i + 1)
                if (p[i])
                    bia_pick = i[2:0];
        end
    endfunction

    // two-stage sync of async pins
    always @(posedge core_clk) begin
        if (!resetn) begin
            irq_s1 <= 7'h7f;
            irq_s2 <= 7'h7f;
            dtk_s1 <= 1'b1;
            dtk_s2 <= 1'b1;
            ack_s1 <= 1'b1;
            ack_s2 <= 1'b1;
        end else begin
            irq_s1 <= irq_n;
            irq_s2 <= irq_s1;
            dtk_s1 <= dtack_in_n;
            dtk_s2 <= dtk_s1;
            ack_s1 <= iackin_n;
            ack_s2 <= ack_s1;
        end
    end

    // straps are pins too; synced so a jumper change cannot split a cycle
    always @(posedge core_clk) begin
        if (!resetn) begin
            en_s1   <= 7'h00;
            en_s2   <= 7'h00;
            slot_s1 <= 1'b0;
            slot_s2 <= 1'b0;
        end else begin
            en_s1   <= line_enable;
            en_s2   <= en_s1;
            slot_s1 <= slot1;
            slot_s2 <= slot_s1;
        end
    end

    assign pend     = ~irq_s2 & en_s2;
    assign top_line = bia_pick(pend);
    assign bus_done = (st == ST_DONE);

    // handler sequence: request, acknowledge, capture
    always @(posedge core_clk) begin
        if (!resetn) begin
            st          <= ST_IDLE;
            bus_req     <= 1'b0;
            addr_out    <= `BIA_CODE_NONE;
            addr_oe_n   <= 1'b1;
            iack_n      <= 1'b1;
            as_n        <= 1'b1;
            ds_n        <= 1'b1;
            vector      <= {ID_W{1'b0}};
            vector_line <= `BIA_CODE_NONE;
            service     <= 1'b0;
        end else begin
            service <= 1'b0;
            case (st)
                ST_IDLE: begin
                    if (bia_live(top_line)) begin
                        bus_req <= 1'b1; // ask requester for the bus
                        st      <= ST_REQ;
                    end
                end
                ST_REQ: begin
                    // line may drop before grant; then give up quietly
                    if (!bia_live(top_line)) begin
                        bus_req <= 1'b0;
                        st      <= ST_IDLE;
                    end else if (bus_grant) begin // wait for grant
                        addr_out  <= top_line;
                        addr_oe_n <= 1'b0;
                        iack_n    <= 1'b0;
                        as_n      <= 1'b0;
                        vector_line <= top_line;
                        st        <= ST_ACK;
                    end
                end
                ST_ACK: begin
                    // strobe one cycle after as, giving address setup
                    ds_n <= 1'b0;
                    st   <= ST_STRB;
                end
                ST_STRB: begin
                    // no timeout here; bus timer outside ends a dead cycle
                    if (!dtk_s2) begin
                        vector    <= data_in;    // capture id
                        service   <= 1'b1;
                        ds_n      <= 1'b1;
                        as_n      <= 1'b1;
                        iack_n    <= 1'b1;
                        addr_oe_n <= 1'b1;
                        st        <= ST_DONE;
                    end
                end
                ST_DONE: begin
                    // wait for dtack to lift before the next request
                    bus_req <= 1'b0;
                    if (dtk_s2)
                        st <= ST_IDLE;
                end
                default: st <= ST_IDLE;
            endcase
        end
    end

    // slot-1 chain driver: falling iack yields falling chain edge
    always @(posedge core_clk) begin
        if (!resetn)
            drv_ack_n <= 1'b1;
        else
            drv_ack_n <= slot_s2 ? ack_s2 : 1'b1;
    end

    // outside slot 1 the chain input feeds the interrupter directly
    assign chain_mid_n = slot_s2 ? drv_ack_n : ack_s2;

    // local interrupter behind the chain driver
    bia_interrupter #(
        .ID_W (ID_W)
    ) u_intr (
        .core_clk  (core_clk),
        .resetn    (resetn),
        .req_line  (local_line),
        .status_id (local_id),
        .ackin_n   (chain_mid_n),
        .addr_code (addr_out),
        .ds_n      (ds_n),
        .ackout_n  (iackout_n),
        .dtack_n   (local_dtack_n),
        .data_oe_n (local_data_oe_n),
        .data_out  (local_data)
    );
endmodule
`default_nettype wire

//--- rtl/bia_defines.vh
// bia_defines.vh: constants for the backplane interrupt acknowledge block
// assumes: included by bare name from rtl files; definitions only
`ifndef BIA_DEFINES_VH
`define BIA_DEFINES_VH

`define BIA_NUM_LINES   7
`define BIA_CODE_W      3
`define BIA_CODE_NONE   3'h0
`define BIA_ID_W        8

// handler states
`define BIA_ST_IDLE     3'h0
`define BIA_ST_REQ      3'h1
`define BIA_ST_ACK      3'h2
`define BIA_ST_STRB     3'h3
`define BIA_ST_DONE     3'h4

// interrupter states
`define BIA_IS_IDLE     2'h0
`define BIA_IS_MATCH    2'h1
`define BIA_IS_PASS     2'h2
`define BIA_IS_RESP     2'h3

`endif

//--- rtl/bia_interrupter.v
// bia_interrupter.v: one interrupter on the acknowledge daisy chain
// assumes: all bus inputs already synchronised to core_clk by the parent
`timescale 1ns/1ps
`default_nettype none
`include "bia_defines.vh"

module bia_interrupter #(
    parameter ID_W = `BIA_ID_W
) (
    input  wire            core_clk,     // system clock
    input  wire            resetn,       // sync reset, active low
    input  wire [2:0]      req_line,     // line this interrupter drives, 0 = none
    input  wire [ID_W-1:0] status_id,    // identifier to return
    input  wire            ackin_n,      // incoming chain, synchronised
    input  wire [2:0]      addr_code,    // a03..a01, synchronised
    input  wire            ds_n,         // any data strobe low, synchronised
    output reg             ackout_n,     // outgoing chain
    output reg             dtack_n,      // acknowledge to handler
    output reg             data_oe_n,    // data bus enable, low drives
    output reg  [ID_W-1:0] data_out      // status/id on the data bus
);
    reg       ackin_d;
    reg [1:0] st;

    // chain edge, match check and response
    always @(posedge core_clk) begin
        if (!resetn) begin
            ackin_d   <= 1'b1;
            st        <= `BIA_IS_IDLE;
            ackout_n  <= 1'b1;
            dtack_n   <= 1'b1;
            data_oe_n <= 1'b1;
            data_out  <= {ID_W{1'b0}};
        end else begin
            ackin_d <= ackin_n;
            case (st)
                `BIA_IS_IDLE: begin
                    ackout_n <= 1'b1;
                    if (ackin_d && !ackin_n) begin
                        // compare code with the line driven low
                        if (req_line != `BIA_CODE_NONE && addr_code == req_line)
                            st <= `BIA_IS_MATCH;
                        else begin
                            ackout_n <= 1'b0; // pass edge on, stay silent
                            st       <= `BIA_IS_PASS;
                        end
                    end
                end
                `BIA_IS_MATCH: begin
                    // wait for strobes, then id and dtack
                    if (!ds_n) begin
                        data_out  <= status_id;
                        data_oe_n <= 1'b0;
                        dtack_n   <= 1'b0;
                        st        <= `BIA_IS_RESP;
                    end else if (ackin_n)
                        st <= `BIA_IS_IDLE;
                end
                `BIA_IS_RESP: begin
                    // hold until handler lifts strobes
                    if (ds_n) begin
                        data_oe_n <= 1'b1;
                        dtack_n   <= 1'b1;
                        st        <= `BIA_IS_IDLE;
                    end
                end
                `BIA_IS_PASS: begin
                    if (ackin_n) begin
                        ackout_n <= 1'b1;
                        st       <= `BIA_IS_IDLE;
                    end
                end
                default: st <= `BIA_IS_IDLE;
            endcase
        end
    end
endmodule
`default_nettype wire

//--- testbench/bia_top_assertions.sv
// bia_top_chk: port timing checks for bia_top
// assumes: bound onto bia_top, chain input tied to iack
`timescale 1ns/1ps
`default_nettype none
module bia_top_chk (
    input wire logic       core_clk,      // clock
    input wire logic       resetn,        // reset
    input wire logic [7:1] line_enable,   // watched
    input wire logic [7:1] irq_n,         // requests
    input wire logic       bus_req,       // request
    input wire logic       bus_grant,     // grant
    input wire logic       bus_done,      // release
    input wire logic [2:0] addr_out,      // code
    input wire logic       addr_oe_n,     // address drive
    input wire logic       iack_n,        // iack
    input wire logic       as_n,          // strobe
    input wire logic       ds_n,          // strobe
    input wire logic       dtack_in_n,    // dtack
    input wire logic       iackout_n,     // chain out
    input wire logic [2:0] local_line,    // local line
    input wire logic       local_dtack_n, // local dtack
    input wire logic       local_data_oe_n, // local data drive
    input wire logic       service        // service
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!resetn);
    // any watched line held low is pending
    wire pend = |(~irq_n & line_enable);
    // request and acknowledge phase
    property p_req; pend [*6] |-> ##[0:3] (bus_req || bus_done); endproperty
    a_req: assert property (p_req) else $error("bus request missing");
    property p_grant; !ds_n |-> bus_grant; endproperty
    a_grant: assert property (p_grant) else $error("strobe before grant");
    property p_ack; $fell(as_n) |-> !iack_n && $past(bus_grant); endproperty
    a_ack: assert property (p_ack) else $error("strobe without iack");
    property p_code; $fell(as_n) |-> addr_out != 3'h0 && !irq_n[addr_out] && line_enable[addr_out]; endproperty
    a_code: assert property (p_code) else $error("code names no pending line");
    // chain and responders
    property p_chain; $fell(iack_n) && local_line != addr_out |-> ##[1:6] !iackout_n; endproperty
    a_chain: assert property (p_chain) else $error("chain edge not passed");
    property p_silent; !as_n && local_line != addr_out |-> local_dtack_n; endproperty
    a_silent: assert property (p_silent) else $error("wrong interrupter answered");
    property p_resp; $fell(local_dtack_n) |-> !$past(ds_n) && local_line == addr_out; endproperty
    a_resp: assert property (p_resp) else $error("local answer out of turn");
    property p_svc; $fell(dtack_in_n) && !iack_n |-> ##[1:6] service ##1 !service; endproperty
    a_svc: assert property (p_svc) else $error("service pulse missing");
    property p_drive; !as_n |-> !addr_oe_n; endproperty
    a_drive: assert property (p_drive) else $error("code not driven under strobe");
    property p_hold; !local_dtack_n |-> !local_data_oe_n && iackout_n; endproperty
    a_hold: assert property (p_hold) else $error("local answer without data or with chain passed");
    c_local: cover property (!local_dtack_n);
    c_pass: cover property (!iackout_n);
    c_svc: cover property (service);
endmodule
bind bia_top bia_top_chk u_chk (.*);
`default_nettype wire

//--- testbench/bia_far_end.sv
// bia_far_end: arbiter and one interrupter down the chain
// assumes: idle dtack pulled up, idle data shows inverted id
`timescale 1ns/1ps
`default_nettype none
module bia_far_end (
    input wire logic       core_clk,  // clock
    input wire logic       bus_req,   // bus wanted
    input wire logic [3:0] grant_dly, // grant wait
    input wire logic       ackin_n,   // chain in
    input wire logic [2:0] addr,      // code
    input wire logic       ds_n,      // strobe
    input wire logic [2:0] line,      // line, 0 none
    input wire logic [7:0] id,        // status/id
    output logic           grant,     // granted
    output logic           dtack_n,   // acknowledge
    output logic [7:0]     data       // data bus
);
    logic [3:0] cnt = 4'h0;
    wire        hit = line != 3'h0 && !ackin_n && addr == line && !ds_n;
    // slow grant mimics a master slow to let go answer own code on strobe
    always @(posedge core_clk) begin
        cnt <= !bus_req ? 4'h0 : (cnt == 4'hf ? cnt : cnt + 4'h1);
        grant <= bus_req && cnt >= grant_dly;
        dtack_n <= !hit;
        data <= hit ? id : ~id;
    end
endmodule
`default_nettype wire

//--- testbench/tb.sv
// tb: acknowledge cycles against the far-end model
// assumes: board in slot 1 except in t_slot, iack wired to its chain input
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic       core_clk = 1'b0, resetn = 1'b0, slot1 = 1'b1;
    logic [7:1] line_enable = 7'h7f, irq_n = 7'h7f;
    logic [2:0] local_line = 3'h0, far_line = 3'h0, code_seen, addr_out, vector_line;
    logic [7:0] local_id = 8'h5a, far_id = 8'hc3, far_data, local_data, vector, data_in;
    logic [3:0] grant_dly = 4'h1;
    logic       bus_req, bus_grant, bus_done, addr_oe_n, iack_n, as_n, ds_n, far_dtack_n;
    logic       iackout_n, local_dtack_n, local_data_oe_n, service, dtack_in_n, iackin_n;
    int         bad_count = 0, tests_run = 0;
    always #25 core_clk = ~core_clk;
    // wired dtack; local responder wins the data bus
    assign dtack_in_n = far_dtack_n & local_dtack_n;
    assign data_in = local_data_oe_n ? far_data : local_data;
    assign iackin_n = iack_n;
    bia_top uut (.*);
    bia_far_end far (.core_clk, .bus_req, .grant_dly, .ackin_n(iackout_n), .addr(addr_out), .ds_n,
        .line(far_line), .id(far_id), .grant(bus_grant), .dtack_n(far_dtack_n), .data(far_data));
    // keep the code shown under the address strobe
    always @(posedge core_clk) if (!as_n) code_seen <= addr_out;
    task automatic chk(input string what, input logic [7:0] exp, got);
        tests_run++;
        if (got !== exp) begin
            bad_count++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    // one full cycle; bounded waits so a stuck handshake cannot hang
    task automatic run(input logic [7:1] en, irq, input logic [2:0] fl, ll,
                       input logic [3:0] gd, input logic [2:0] ln, input logic [7:0] id);
        line_enable = en;
        irq_n = ~irq;
        far_line = fl;
        local_line = ll;
        grant_dly = gd;
        repeat (200) if (dtack_in_n !== 1'b0) @(posedge core_clk) #1;
        irq_n = 7'h7f; // responders drop their line once acknowledged
        repeat (20) if (service !== 1'b1) @(posedge core_clk) #1;
        chk("service", 8'h1, {7'h0, service});
        chk("line", {5'h0, ln}, {5'h0, vector_line});
        chk("code", {5'h0, ln}, {5'h0, code_seen});
        chk("vector", id, vector);
        repeat (50) if (bus_done !== 1'b0 || dtack_in_n !== 1'b1) @(posedge core_clk) #1;
        repeat (3) @(posedge core_clk) #1;
    endtask
    task automatic t_codes;
        for (int n = 1; n <= 7; n++) run(7'h7f, 7'h1 << (n - 1), n[2:0], 3'h0, 4'h1, n[2:0], 8'hc3);
    endtask
    task automatic t_prio; run(7'h7f, 7'h62, 3'h7, 3'h0, 4'h9, 3'h7, 8'hc3); endtask
    task automatic t_subset; run(7'h0f, 7'h24, 3'h3, 3'h0, 4'h3, 3'h3, 8'hc3); endtask
    task automatic t_local; run(7'h7f, 7'h10, 3'h5, 3'h5, 4'h0, 3'h5, 8'h5a); endtask
    task automatic t_pass; run(7'h7f, 7'h22, 3'h6, 3'h2, 4'hf, 3'h6, 8'hc3); endtask
    // board outside slot 1: chain input bypasses the driver
    task automatic t_slot;
        slot1 = 1'b0;
        run(7'h7f, 7'h04, 3'h3, 3'h0, 4'h2, 3'h3, 8'hc3);
        slot1 = 1'b1;
    endtask
    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    initial begin
        repeat (12) @(posedge core_clk);
        #1;
        resetn = 1'b1;
        t_codes();
        t_prio();
        t_subset();
        t_local();
        t_pass();
        t_slot();
        wrap_up();
    end
    // watchdog at about thirty-five times the expected run
    initial begin
        #500000;
        bad_count++;
        wrap_up();
    end
endmodule
`default_nettype wire
